// ===== common/tsr_regs.vh
// Constants for the temperature sensor register set and its two-wire slave port
`ifndef TSR_REGS_VH
`define TSR_REGS_VH
`define TSR_CMD_THERMAL     8'h00
`define TSR_CMD_SETUP       8'h01
`define TSR_SETUP_STANDBY   7
`define TSR_SETUP_READY     6
`define TSR_THERMAL_RESET   8'h00
`define TSR_SETUP_RESET     8'h00
`define TSR_THERMAL_MAX     8'h7f
`define TSR_THERMAL_MIN     8'h80
`define TSR_ROUND_HALF      16'h0080
`define TSR_SAT_THRESHOLD   16'h7e80
`define TSR_CONV_PERIOD_NS  125000000
`define TSR_CLK_PERIOD_NS   4
`define TSR_SLAVE_ADDR      7'h48
`endif

// ===== hdl/tsr_sensor_regs.v
// Temperature sensor register set with two-wire serial slave port
`timescale 1ns/1ps
`default_nettype none
`include "tsr_regs.vh"

// Summary of operation
// RL1 - Setup register: standby in bit 7, ready in bit 6, bits 5..0 read zero.
// RL2 - Setup is writable; standby 1 enters standby, 0 normal; writes never touch ready.
// RL3 - Ready clears at reset and when standby set; rises only with a valid result.
// RL4 - Thermal reading loads at end of every conversion; host cannot write it.
// RL5 - Reading is 8-bit two's complement, one count per degree Celsius.
// RL6 - Round to nearest degree, halves upward; saturate at +126.5 and above to 7Fh.
// RL7 - Thermal reading is fresh whenever the ready flag is seen set.
// RL8 - Both registers reset to zero; thermal read-only, setup read/write.
// RL9 - Conversions repeat automatically in normal operation, no host command needed.
// RL10 - Command byte 00h selects thermal reading, 01h selects setup register.
// RL11 - Address byte bit eight: 1 read, 0 write; command byte sent by a write.
// RL12 - In standby no conversion starts; last reading is held.
// RL13 - Setup write keeps only bit 7; read-back is standby, ready, zeros.
module tsr_sensor_regs #(
    // Default counts one conversion period at the core clock rate
    parameter [31:0] CONV_CYCLES = `TSR_CONV_PERIOD_NS / `TSR_CLK_PERIOD_NS
) (
    input  wire         CORE_CLK_I,
    input  wire         RSTN_I,
    input  wire         SCL_I,
    input  wire         SDA_I,
    output reg          SDA_O,
    output reg          SDA_OE_N_O,
    input  wire [15:0]  SENSE_Q8_I,
    output reg          STANDBY_O,
    output reg          READY_O
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops per pin keep a metastable level away from the decoders
    reg  [1:0]  scl_sync;
    reg  [1:0]  sda_sync;
    reg         scl_d;
    reg         sda_d;

    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], SCL_I};
            sda_sync <= {sda_sync[0], SDA_I};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    // ----------------------------------------------------------------
    // Bus conditions
    // ----------------------------------------------------------------
    // Start and stop need the clock high on both samples, so a data change
    // racing a clock edge is never mistaken for either.
    wire scl      = scl_sync[1];
    wire sda      = sda_sync[1];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c  = scl & scl_d & sda_d & ~sda;
    wire stop_c   = scl & scl_d & ~sda_d & sda;

    // ----------------------------------------------------------------
    // Rounding and saturation
    // ----------------------------------------------------------------
    // The analog sample arrives as signed degrees with eight fraction bits.
    // Adding one half then flooring rounds halves toward positive.
    // Inputs below -128 degrees wrap; the sensing element never reaches them.
    reg  [15:0] sum;
    reg  [7:0]  rounded;
    wire        sense_pos  = ~SENSE_Q8_I[15];
    wire        sense_high = (SENSE_Q8_I >= `TSR_SAT_THRESHOLD);

    always @* begin
        sum     = SENSE_Q8_I + `TSR_ROUND_HALF;
        rounded = sum[15:8];                                          // see RL5, RL6
        // A carry into the sign bit only comes from a large positive input
        if (sense_pos && (sum[15] || sense_high)) begin
            rounded = `TSR_THERMAL_MAX;                               // see RL6
        end
    end

    // ----------------------------------------------------------------
    // Conversion engine
    // ----------------------------------------------------------------
    // Standby holds the counter at zero, so every wake-up waits a full period
    // before the first fresh reading.
    reg  [31:0] conv_cnt;
    reg  [7:0]  thermal_reading_reg;
    reg         standby_request;
    reg         ready;

    wire conv_done = !standby_request && (conv_cnt == CONV_CYCLES - 32'h1);

    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            conv_cnt <= 32'h0;
        end else if (standby_request || conv_done) begin
            conv_cnt <= 32'h0;                                        // see RL9, RL12
        end else begin
            conv_cnt <= conv_cnt + 32'h1;
        end
    end

    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            thermal_reading_reg <= `TSR_THERMAL_RESET;                // see RL8
        end else if (conv_done) begin
            thermal_reading_reg <= rounded;                           // see RL4, RL5, RL7
        end
    end

    // Ready rises on the edge that loads the reading, so a host that sees it
    // set reads the new value; standby wins over a conversion ending with it.
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ready <= 1'b0;                                            // see RL3
        end else if (standby_request) begin
            ready <= 1'b0;                                            // see RL3
        end else if (conv_done) begin
            ready <= 1'b1;                                            // see RL3, RL7
        end
    end

    // ----------------------------------------------------------------
    // Two-wire slave
    // ----------------------------------------------------------------
    // Address, command and data bytes all shift in on rising clock edges.
    // The acknowledge is driven from the eighth falling edge to the ninth.
    // Read data leaves one bit per falling edge, most significant first;
    // the slave lets go after the eighth bit so the master can answer.
    // A wrong address drops back to idle until the next start condition.
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_AACK = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_WACK = 3'h4;
    localparam ST_RD   = 3'h5;
    localparam ST_RACK = 3'h6;

    reg  [2:0]  state;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shift;
    reg         rd_mode;
    reg         got_cmd;
    reg  [7:0]  command;
    reg         drive_low;
    reg  [7:0]  out_byte;

    // ----------------------------------------------------------------
    // Read-back multiplexer
    // ----------------------------------------------------------------
    wire [7:0] setup_view = {standby_request, ready, 6'h00};          // see RL1, RL13

    always @* begin
        if (command == `TSR_CMD_SETUP) begin                          // see RL10
            out_byte = setup_view;
        end else begin
            out_byte = thermal_reading_reg;
        end
    end

    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state           <= ST_IDLE;
            bit_cnt         <= 4'h0;
            shift           <= 8'h00;
            rd_mode         <= 1'b0;
            got_cmd         <= 1'b0;
            command         <= `TSR_CMD_THERMAL;
            drive_low       <= 1'b0;
        end else if (start_c) begin
            state     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            got_cmd   <= 1'b0;
            drive_low <= 1'b0;
        end else if (stop_c) begin
            state     <= ST_IDLE;
            drive_low <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    drive_low <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        if (shift[7:1] == `TSR_SLAVE_ADDR) begin
                            rd_mode   <= shift[0];                    // see RL11
                            drive_low <= 1'b1;
                            state     <= ST_AACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (rd_mode) begin
                            shift     <= out_byte;
                            drive_low <= ~out_byte[7];
                            state     <= ST_RD;
                        end else begin
                            drive_low <= 1'b0;
                            state     <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        // A data byte aimed at the thermal reading is acked and dropped
                        if (!got_cmd) begin
                            command <= shift;                         // see RL10, RL11
                            got_cmd <= 1'b1;
                        end
                        drive_low <= 1'b1;
                        state     <= ST_WACK;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            drive_low <= 1'b0;
                            state     <= ST_RACK;
                        end else begin
                            shift     <= {shift[6:0], 1'b0};
                            drive_low <= ~shift[6];
                            bit_cnt   <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // A master ack asks for another copy; a nack ends the read
                    if (scl_rise) begin
                        bit_cnt <= 4'h0;
                        state   <= sda ? ST_IDLE : ST_AACK;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Setup register
    // ----------------------------------------------------------------
    // The data byte of a setup write is complete at the eighth falling edge;
    // start and stop need the clock high, so neither can share that cycle.
    wire setup_wr = (state == ST_WR) && scl_fall && (bit_cnt == 4'h8) && got_cmd
                    && (command == `TSR_CMD_SETUP);                   // see RL10

    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            standby_request <= 1'b0;                                  // see RL8
        end else if (setup_wr) begin
            // Only the standby bit is stored; ready stays hardware-owned
            standby_request <= shift[`TSR_SETUP_STANDBY];             // see RL2, RL13
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            SDA_O      <= 1'b1;
            SDA_OE_N_O <= 1'b1;
            STANDBY_O  <= 1'b0;
            READY_O    <= 1'b0;
        end else begin
            // Open drain: the value stays low and only the enable moves
            SDA_O      <= 1'b0;
            SDA_OE_N_O <= ~drive_low;
            STANDBY_O  <= standby_request;
            READY_O    <= ready;
        end
    end

endmodule
`default_nettype wire

// ===== verification/tsr_sensor_regs_properties.sv
// Port assertions for the sensor register set
`timescale 1ns/1ps
`default_nettype none
module tsr_sensor_regs_properties #(
    parameter [31:0] CONV_CYCLES = 32'h14
) (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_N_O,
    input wire logic STANDBY_O,
    input wire logic READY_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    logic [31:0] wait_cnt;
    // Awake cycles still waiting for a result; the margin covers the output flops
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wait_cnt <= 32'h0;
        end else begin
            wait_cnt <= (STANDBY_O || READY_O) ? 32'h0 : wait_cnt + 32'h1;
        end
    end
    a_ready_in_time: assert property (wait_cnt <= CONV_CYCLES + 32'h4)
        else $error("ready flag late");
    a_standby_clr_ready: assert property ($rose(STANDBY_O) |-> ##[0:2] !READY_O)
        else $error("ready kept after standby");
    a_standby_no_ready: assert property (STANDBY_O && $past(STANDBY_O, 3) |-> !READY_O)
        else $error("ready rose in standby");
    a_ready_when_awake: assert property ($rose(READY_O) |-> !STANDBY_O && $past(STANDBY_O, 8) == 1'b0)
        else $error("ready rose too soon");
    a_ready_drop_cause: assert property ($fell(READY_O) |-> STANDBY_O)
        else $error("ready fell without standby");
    a_setup_then_ack: assert property ($changed(STANDBY_O) |-> ##[0:6] !SDA_OE_N_O)
        else $error("standby changed without ack");
    a_drive_scl_low: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
        else $error("data line changed with clock high");
    a_drive_pulls_low: assert property (!SDA_OE_N_O |-> !SDA_O)
        else $error("driven data line not low");
endmodule
bind tsr_sensor_regs tsr_sensor_regs_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (
    .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .SCL_I(SCL_I), .SDA_O(SDA_O),
    .SDA_OE_N_O(SDA_OE_N_O), .STANDBY_O(STANDBY_O), .READY_O(READY_O));
`default_nettype wire

// ===== verification/tsr_host_model.sv
// Two-wire bus master in place of the host controller
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model #(
    parameter int HALF = 12
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Only one line moves per step, so no false start or stop is made
    task automatic step(input logic c, input logic d);
        scl_o <= c;
        sda_o <= d;
        repeat (HALF) @(posedge clk_i);
    endtask
    task automatic start_cond();
        step(1'b0, sda_o);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic stop_cond();
        step(1'b0, sda_o);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // Nine bits MSB first; a released bit lets the slave answer
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, sda_o);
            step(1'b0, tx[i]);
            step(1'b1, tx[i]);
            rx[i] = sda_i;
        end
    endtask
endmodule
`default_nettype wire

// ===== verification/tsr_sensor_regs_tb_top.sv
// Self-checking bench for the sensor register set
`timescale 1ns/1ps
`default_nettype none
`include "tsr_regs.vh"
module tsr_sensor_regs_tb_top;
    typedef struct packed { logic [15:0] sense; logic [7:0] code; } tsr_row_t;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] sense = 16'h0000;
    logic        scl, sda_host, sda_o, sda_oe_n, standby, ready;
    logic [8:0]  rx;
    int          n_mismatch = 0;
    int          check_count = 0;
    wire logic   sda_wire = sda_host & (sda_oe_n | sda_o);
    // Sensed value in 1/256 degree steps beside the code it must give
    tsr_row_t rows [13] = '{'{16'h7f80, 8'h7f}, '{16'h7f00, 8'h7f}, '{16'h7e80, 8'h7f}, '{16'h7e40, 8'h7e},
        '{16'h1940, 8'h19}, '{16'h0080, 8'h01}, '{16'h0040, 8'h00}, '{16'hffc0, 8'h00}, '{16'hff80, 8'h00},
        '{16'hff40, 8'hff}, '{16'he700, 8'he7}, '{16'hc940, 8'hc9}, '{16'hbf00, 8'hbf}};
    tsr_sensor_regs #(.CONV_CYCLES(32'h14)) u_dut (
        .CORE_CLK_I(core_clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda_wire), .SDA_O(sda_o),
        .SDA_OE_N_O(sda_oe_n), .SENSE_Q8_I(sense), .STANDBY_O(standby), .READY_O(ready));
    tsr_host_model u_host (.clk_i(core_clk), .sda_i(sda_wire), .scl_o(scl), .sda_o(sda_host));
    always #2 core_clk = ~core_clk;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic byte_out(input logic [7:0] b);
        u_host.xfer({b, 1'b1}, rx);
        check({7'h0, rx[0]}, 8'h00);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        u_host.start_cond();
        byte_out({`TSR_SLAVE_ADDR, 1'b0});
        byte_out(cmd);
        byte_out(data);
        u_host.stop_cond();
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        u_host.start_cond();
        byte_out({`TSR_SLAVE_ADDR, 1'b0});
        byte_out(cmd);
        u_host.start_cond();
        byte_out({`TSR_SLAVE_ADDR, 1'b1});
        u_host.xfer(9'h1ff, rx);
        u_host.stop_cond();
        check(rx[8:1], exp);
    endtask
    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        check({6'h0, standby, ready}, 8'h00);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        foreach (rows[i]) begin
            sense <= rows[i].sense;
            repeat (44) @(posedge core_clk);
            rd(`TSR_CMD_THERMAL, rows[i].code);
        end
        rd(`TSR_CMD_SETUP, 8'h40);
        wr(`TSR_CMD_SETUP, 8'hff);
        rd(`TSR_CMD_SETUP, 8'h80);
        sense <= 16'h1000;
        repeat (80) @(posedge core_clk);
        rd(`TSR_CMD_THERMAL, 8'hbf);
        wr(`TSR_CMD_SETUP, 8'hc0);
        rd(`TSR_CMD_SETUP, 8'h80);
        wr(`TSR_CMD_THERMAL, 8'h55);
        rd(`TSR_CMD_THERMAL, 8'hbf);
        wr(`TSR_CMD_SETUP, 8'h00);
        rd(`TSR_CMD_SETUP, 8'h40);
        rd(`TSR_CMD_THERMAL, 8'h10);
        u_host.start_cond();
        u_host.xfer({`TSR_SLAVE_ADDR ^ 7'h01, 1'b0, 1'b1}, rx);
        u_host.stop_cond();
        check({7'h0, rx[0]}, 8'h01);
        test_done();
    end
    // About 34000 cycles are needed; the limit leaves ample room
    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
